// >>> logic/usc_cfg.svh
`ifndef USC_CFG_SVH
`define USC_CFG_SVH

// register byte addresses
`define USC_ADDR_CTRL      32'h400e0600
`define USC_ADDR_INT_EN    32'h400e0608
`define USC_ADDR_INT_DIS   32'h400e060c
`define USC_ADDR_MASK      32'h400e0610
`define USC_ADDR_STATUS    32'h400e0614
`define USC_ADDR_RX_HOLD   32'h400e0618
`define USC_ADDR_TX_HOLD   32'h400e061c
`define USC_ADDR_BAUD      32'h400e0620
`define USC_ADDR_MATCH     32'h400e0624
`define USC_ADDR_LOCK      32'h400e06e4

// status and mask bit positions
`define USC_BIT_RX_AVAIL   0
`define USC_BIT_TX_FREE    1
`define USC_BIT_RX_DMA     3
`define USC_BIT_TX_DMA     4
`define USC_BIT_OVERRUN    5
`define USC_BIT_FRAME      6
`define USC_BIT_PARITY     7
`define USC_BIT_TX_IDLE    9
`define USC_BIT_TX_BUFE    11
`define USC_BIT_RX_BUFF    12
`define USC_BIT_MATCH      15
`define USC_INT_BITS       16'h9afb

// control bits
`define USC_CTRL_CLR_STAT  8
`define USC_CTRL_REARM     12

// match window fields
`define USC_MW_LOW_LSB     0
`define USC_MW_GATE_BIT    12
`define USC_MW_PAR_BIT     14
`define USC_MW_HIGH_LSB    16

// write lock
`define USC_LOCK_KEY       24'h554152
`define USC_LOCK_EN_BIT    0

// baud generator
`define USC_OVERSAMPLE     16
`define USC_DIV_RESET      16'h0000

`endif

// >>> logic/usc_pkg.sv
`default_nettype none
package usc_pkg;

    typedef struct packed {
        logic [15:0] intMask;
        logic        rxAvail;
        logic        overrun;
        logic        frameErr;
        logic        parityErr;
        logic        match;
        logic [7:0]  rxChar;
        logic [7:0]  txChar;
        logic        txValid;
        logic [15:0] divisor;
        logic [7:0]  matchLow;
        logic [7:0]  matchHigh;
        logic        gateSel;
        logic        parCheck;
        logic        lockEn;
        logic        armed;
        logic        wakeReq;
        logic [31:0] rdData;
    } usc_state_t;

    typedef struct packed {
        logic [15:0] divCnt;
        logic [3:0]  subCnt;
        logic        sampleTick;
        logic        bitTick;
    } usc_baud_state_t;

endpackage : usc_pkg
`default_nettype wire

// >>> logic/usc_match_if.sv
`timescale 1ns/1ps
`default_nettype none
interface usc_match_if;
    logic [7:0] rxChar;
    logic [7:0] low;
    logic [7:0] high;
    logic       parityErr;
    logic       parCheck;
    logic       hit;

    modport unit (input rxChar, input low, input high, input parityErr, input parCheck,
                  output hit);
    modport host (output rxChar, output low, output high, output parityErr,
                  output parCheck, input hit);
endinterface : usc_match_if
`default_nettype wire

// >>> logic/usc_match_unit.sv
`timescale 1ns/1ps
`default_nettype none
module usc_match_unit (
    usc_match_if.unit m
);
    logic inWindow;

    assign inWindow = (m.rxChar >= m.low) && (m.rxChar <= m.high);
    // a bad parity only vetoes the hit when the check is switched on
    assign m.hit    = inWindow && !(m.parCheck && m.parityErr);
endmodule : usc_match_unit
`default_nettype wire

// >>> logic/usc_baud_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "usc_cfg.svh"
module usc_baud_gen #(
    parameter int DIV_W = 16
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [DIV_W-1:0] divisor,
    output logic                  sampleTick,
    output logic                  bitTick
);
    if (DIV_W < 1 || DIV_W > 16) begin : g_chk
        $error("usc_baud_gen: DIV_W must be 1..16");
    end

    usc_pkg::usc_baud_state_t cur_reg;
    usc_pkg::usc_baud_state_t cur_next;

    always_comb begin
        cur_next            = cur_reg;
        cur_next.sampleTick = 1'b0;
        cur_next.bitTick    = 1'b0;
        if (divisor == '0) begin
            cur_next.divCnt = 16'h0000;
            cur_next.subCnt = 4'h0;
        end else if (cur_reg.divCnt >= 16'(divisor - 1'b1)) begin
            cur_next.divCnt     = 16'h0000;
            cur_next.sampleTick = 1'b1;
            cur_next.subCnt     = cur_reg.subCnt + 4'h1;
            // one bit period every sixteen sample ticks
            cur_next.bitTick    = (cur_reg.subCnt == 4'(`USC_OVERSAMPLE - 1));
        end else begin
            cur_next.divCnt = cur_reg.divCnt + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_reg <= '0;
        end else begin
            cur_reg <= cur_next;
        end
    end

    assign sampleTick = cur_reg.sampleTick;
    assign bitTick    = cur_reg.bitTick;
endmodule : usc_baud_gen
`default_nettype wire

// >>> logic/usc_status_regs.sv
// Contract
// - mask view bit reads 1 when its interrupt is enabled; read-only
// - rx char available set on char load, cleared by read or receiver disable
// - tx hold free is 0 while a char waits or transmitter disabled
// - status bits 3 and 4 mirror receive and transmit dma done
// - overrun flag bit 5 sticky until status clear command
// - framing error flag bit 6 sticky until status clear command
// - parity error flag bit 7 sticky until status clear command
// - tx idle bit 9 set only when hold empty, shifter idle, enabled
// - bits 11 and 12 mirror tx dma buffer empty and rx dma buffer full
// - match flag bit 15 set on matching char, sticky until status clear
// - rx holding read returns last received char in bits 7:0
// - tx holding write queues char behind the one shifting out
// - divisor zero stops baud clock; else rate is clock over 16 times divisor
// - match needs char between low and high values inclusive
// - match requests wake-up when partial wake is enabled
// - gate mode 0 takes all chars; mode 1 waits for a match
// - parity check on cancels match and wake-up on parity error
// - lock enable changes only with key 0x554152 in bits 31:8
// - match window layout: low 7:0, gate 12, parity 14, high 23:16
// - status clear command clears parity, framing, match and overrun flags
// - enable write sets mask bits, disable write clears them
// - wrong key discards lock write; key field reads zero
`timescale 1ns/1ps
`default_nettype none
`include "usc_cfg.svh"
module usc_status_regs (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [31:0] busAddr,
    input  wire logic [31:0] busWdata,
    input  wire logic        busWrite,
    input  wire logic        busRead,
    output logic      [31:0] busRdata,
    input  wire logic        rxCharStrobe,
    input  wire logic [7:0]  rxCharData,
    input  wire logic        rxParityErr,
    input  wire logic        rxFrameErr,
    input  wire logic        rxEnabled,
    input  wire logic        txEnabled,
    input  wire logic        txShiftBusy,
    input  wire logic        txTake,
    input  wire logic        rxDmaDone,
    input  wire logic        txDmaDone,
    input  wire logic        txDmaBufEmpty,
    input  wire logic        rxDmaBufFull,
    input  wire logic        partialWakeEnable,
    output logic             rxGateOpen,
    output logic             txHoldValid,
    output logic      [7:0]  txHoldChar,
    output logic             sampleTick,
    output logic             bitTick,
    output logic             wakeReq,
    output logic             irq
);
    usc_pkg::usc_state_t cur_reg;
    usc_pkg::usc_state_t cur_next;

    usc_match_if matchBus ();

    logic        wrCtrl;
    logic        wrIntEn;
    logic        wrIntDis;
    logic        wrTxHold;
    logic        wrBaud;
    logic        wrMatch;
    logic        wrLock;
    logic        rdRxHold;
    logic        clrStatus;
    logic        accept;
    logic        charLoad;
    logic [31:0] statusWord;

    usc_match_unit u_match (
        .m (matchBus.unit)
    );

    usc_baud_gen #(
        .DIV_W (16)
    ) u_baud (
        .clk        (clk),
        .rst_n      (rst_n),
        .divisor    (cur_reg.divisor),
        .sampleTick (sampleTick),
        .bitTick    (bitTick)
    );

    assign matchBus.rxChar    = rxCharData;
    assign matchBus.low       = cur_reg.matchLow;
    assign matchBus.high      = cur_reg.matchHigh;
    assign matchBus.parityErr = rxParityErr;
    assign matchBus.parCheck  = cur_reg.parCheck;

    assign wrCtrl    = busWrite && (busAddr == `USC_ADDR_CTRL);
    assign wrIntEn   = busWrite && (busAddr == `USC_ADDR_INT_EN);
    assign wrIntDis  = busWrite && (busAddr == `USC_ADDR_INT_DIS);
    assign wrTxHold  = busWrite && (busAddr == `USC_ADDR_TX_HOLD);
    assign wrBaud    = busWrite && (busAddr == `USC_ADDR_BAUD);
    assign wrMatch   = busWrite && (busAddr == `USC_ADDR_MATCH);
    assign wrLock    = busWrite && (busAddr == `USC_ADDR_LOCK);
    assign rdRxHold  = busRead && (busAddr == `USC_ADDR_RX_HOLD);
    assign clrStatus = wrCtrl && busWdata[`USC_CTRL_CLR_STAT];

    // in gate mode 1 the matching character itself opens the gate and is kept
    assign accept   = !cur_reg.gateSel || cur_reg.armed || matchBus.hit;
    assign charLoad = rxCharStrobe && accept;

    always_comb begin
        statusWord                     = 32'h0000_0000;
        statusWord[`USC_BIT_RX_AVAIL]  = cur_reg.rxAvail;
        statusWord[`USC_BIT_TX_FREE]   = txEnabled && !cur_reg.txValid;
        statusWord[`USC_BIT_RX_DMA]    = rxDmaDone;
        statusWord[`USC_BIT_TX_DMA]    = txDmaDone;
        statusWord[`USC_BIT_OVERRUN]   = cur_reg.overrun;
        statusWord[`USC_BIT_FRAME]     = cur_reg.frameErr;
        statusWord[`USC_BIT_PARITY]    = cur_reg.parityErr;
        statusWord[`USC_BIT_TX_IDLE]   = txEnabled && !cur_reg.txValid && !txShiftBusy;
        statusWord[`USC_BIT_TX_BUFE]   = txDmaBufEmpty;
        statusWord[`USC_BIT_RX_BUFF]   = rxDmaBufFull;
        statusWord[`USC_BIT_MATCH]     = cur_reg.match;
    end

    always_comb begin
        cur_next = cur_reg;

        // clears first, so that a same-cycle event below wins
        if (clrStatus) begin
            cur_next.parityErr = 1'b0;
            cur_next.frameErr  = 1'b0;
            cur_next.overrun   = 1'b0;
            cur_next.match     = 1'b0;
        end
        if (wrCtrl && busWdata[`USC_CTRL_REARM]) begin
            cur_next.armed   = 1'b0;
            cur_next.wakeReq = 1'b0;
        end

        if (wrIntEn) begin
            cur_next.intMask = cur_next.intMask | (busWdata[15:0] & `USC_INT_BITS);
        end
        if (wrIntDis) begin
            cur_next.intMask = cur_next.intMask & ~(busWdata[15:0] & `USC_INT_BITS);
        end

        if (rdRxHold || !rxEnabled) begin
            cur_next.rxAvail = 1'b0;
        end

        if (wrTxHold) begin
            cur_next.txValid = 1'b1;
            cur_next.txChar  = busWdata[7:0];
        end else if (txTake) begin
            cur_next.txValid = 1'b0;
        end

        // locked registers silently keep their value
        if (wrBaud && !cur_reg.lockEn) begin
            cur_next.divisor = busWdata[15:0];
        end
        if (wrMatch && !cur_reg.lockEn) begin
            cur_next.matchLow  = busWdata[`USC_MW_LOW_LSB +: 8];
            cur_next.matchHigh = busWdata[`USC_MW_HIGH_LSB +: 8];
            cur_next.gateSel   = busWdata[`USC_MW_GATE_BIT];
            cur_next.parCheck  = busWdata[`USC_MW_PAR_BIT];
        end
        if (wrLock && busWdata[31:8] == `USC_LOCK_KEY) begin
            cur_next.lockEn = busWdata[`USC_LOCK_EN_BIT];
        end

        if (rxCharStrobe && matchBus.hit) begin
            cur_next.match = 1'b1;
            if (cur_reg.gateSel) begin
                cur_next.armed = 1'b1;
            end
            if (partialWakeEnable) begin
                cur_next.wakeReq = 1'b1;
            end
        end
        if (charLoad) begin
            // unread old char being replaced is an overrun unless read this cycle
            if (cur_reg.rxAvail && !rdRxHold) begin
                cur_next.overrun = 1'b1;
            end
            if (rxParityErr) begin
                cur_next.parityErr = 1'b1;
            end
            cur_next.rxAvail = rxEnabled;
            cur_next.rxChar  = rxCharData;
        end
        if (rxFrameErr) begin
            cur_next.frameErr = 1'b1;
        end

        cur_next.rdData = 32'h0000_0000;
        if (busRead) begin
            unique case (busAddr)
                `USC_ADDR_MASK:    cur_next.rdData = {16'h0000, cur_reg.intMask};
                `USC_ADDR_STATUS:  cur_next.rdData = statusWord;
                `USC_ADDR_RX_HOLD: cur_next.rdData = {24'h000000, cur_reg.rxChar};
                `USC_ADDR_BAUD:    cur_next.rdData = {16'h0000, cur_reg.divisor};
                `USC_ADDR_MATCH: begin
                    cur_next.rdData[`USC_MW_LOW_LSB +: 8]  = cur_reg.matchLow;
                    cur_next.rdData[`USC_MW_HIGH_LSB +: 8] = cur_reg.matchHigh;
                    cur_next.rdData[`USC_MW_GATE_BIT]      = cur_reg.gateSel;
                    cur_next.rdData[`USC_MW_PAR_BIT]       = cur_reg.parCheck;
                end
                `USC_ADDR_LOCK:    cur_next.rdData = {31'h0, cur_reg.lockEn};
                default:           cur_next.rdData = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_reg <= '0;
        end else begin
            cur_reg <= cur_next;
        end
    end

    assign busRdata    = cur_reg.rdData;
    assign rxGateOpen  = !cur_reg.gateSel || cur_reg.armed;
    assign txHoldValid = cur_reg.txValid;
    assign txHoldChar  = cur_reg.txChar;
    assign wakeReq     = cur_reg.wakeReq;
    assign irq         = |(statusWord[15:0] & cur_reg.intMask);

    AST_RX_AVAIL_SET: assert property (@(posedge clk) disable iff (!rst_n)
        charLoad && rxEnabled |=> statusWord[`USC_BIT_RX_AVAIL])
        else $error("rx char available not set after load");

    AST_RX_AVAIL_READ: assert property (@(posedge clk) disable iff (!rst_n)
        rdRxHold && !charLoad |=> !statusWord[`USC_BIT_RX_AVAIL])
        else $error("rx char available not cleared by read");

    AST_TX_FREE_LOW: assert property (@(posedge clk) disable iff (!rst_n)
        wrTxHold |=> !statusWord[`USC_BIT_TX_FREE] && txHoldChar == $past(busWdata[7:0]))
        else $error("tx hold free still high after write");

    AST_OVERRUN_STICKY: assert property (@(posedge clk) disable iff (!rst_n)
        cur_reg.overrun && !clrStatus |=> cur_reg.overrun)
        else $error("overrun flag dropped without clear");

    AST_STATUS_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
        clrStatus && !rxCharStrobe && !rxFrameErr
        |=> !cur_reg.parityErr && !cur_reg.frameErr && !cur_reg.overrun && !cur_reg.match)
        else $error("status clear left a flag set");

    AST_TX_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
        statusWord[`USC_BIT_TX_IDLE] |-> txEnabled && !txHoldValid && !txShiftBusy)
        else $error("tx idle reported while busy or disabled");

    AST_MATCH_WAKE: assert property (@(posedge clk) disable iff (!rst_n)
        rxCharStrobe && rxCharData >= cur_reg.matchLow && rxCharData <= cur_reg.matchHigh
        && !(cur_reg.parCheck && rxParityErr) && partialWakeEnable
        |=> wakeReq && statusWord[`USC_BIT_MATCH])
        else $error("match did not raise flag and wake request");

    AST_DIV_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
        cur_reg.divisor == 16'h0000 [*2] |=> !sampleTick)
        else $error("baud tick with zero divisor");

    AST_LOCKED_BAUD: assert property (@(posedge clk) disable iff (!rst_n)
        wrBaud && cur_reg.lockEn |=> cur_reg.divisor == $past(cur_reg.divisor))
        else $error("locked divisor changed");

    AST_LOCK_READ: assert property (@(posedge clk) disable iff (!rst_n)
        busRead && busAddr == `USC_ADDR_LOCK |=> busRdata[31:8] == 24'h000000)
        else $error("lock key field read nonzero");

    AST_RX_READ_DATA: assert property (@(posedge clk) disable iff (!rst_n)
        rdRxHold |=> busRdata[7:0] == $past(cur_reg.rxChar))
        else $error("rx holding read wrong char");

    AST_IRQ_MASK: assert property (@(posedge clk) disable iff (!rst_n)
        wrIntDis && busWdata[15:0] == `USC_INT_BITS && !wrIntEn |=> !irq)
        else $error("irq high with all sources disabled");

    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    AST_MASK_SET: assert property (
        wrIntEn
        |=> ((cur_reg.intMask | ~$past(busWdata[15:0])) & `USC_INT_BITS)
            == `USC_INT_BITS)
        else $error("mask not set");

    AST_MASK_CLR: assert property (
        wrIntDis
        |=> (cur_reg.intMask & $past(busWdata[15:0])) == 16'h0000)
        else $error("mask not cleared");

    AST_FRAME_STICKY: assert property (
        cur_reg.frameErr && !clrStatus
        |=> cur_reg.frameErr)
        else $error("frame flag dropped");

    AST_MATCH_STICKY: assert property (
        cur_reg.match && !clrStatus
        |=> cur_reg.match)
        else $error("match flag dropped");

    AST_GATE_DROP: assert property (
        rxCharStrobe && !rxGateOpen
        && !matchBus.hit
        |=> cur_reg.rxChar == $past(cur_reg.rxChar))
        else $error("char passed closed gate");

    AST_TX_TAKE: assert property (
        txTake && !wrTxHold
        |=> !txHoldValid)
        else $error("tx hold not freed");

    AST_LOCK_KEY: assert property (
        wrLock
        && busWdata[31:8] != `USC_LOCK_KEY
        |=> cur_reg.lockEn == $past(cur_reg.lockEn))
        else $error("lock changed by bad key");

    AST_LOCK_SET: assert property (
        wrLock
        && busWdata[31:8] == `USC_LOCK_KEY
        |=> cur_reg.lockEn == $past(busWdata[`USC_LOCK_EN_BIT]))
        else $error("lock not taken");

    AST_PARITY_VETO: assert property (
        rxCharStrobe && cur_reg.parCheck
        && rxParityErr && !cur_reg.match
        |=> !cur_reg.match)
        else $error("match despite bad parity");

    AST_RX_OFF: assert property (
        !rxEnabled
        |=> !cur_reg.rxAvail)
        else $error("rx char kept while off");

    AST_OVERRUN_SET: assert property (
        charLoad && cur_reg.rxAvail && !rdRxHold
        |=> cur_reg.overrun)
        else $error("overrun not flagged");

endmodule : usc_status_regs
`default_nettype wire

// >>> tb/usc_line_partner.sv
`timescale 1ns/1ps
`default_nettype none
module usc_line_partner (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       txHoldValid,
    input  wire logic [7:0] txHoldChar,
    output logic            txShiftBusy,
    output logic            txTake,
    output logic            rxCharStrobe,
    output logic      [7:0] rxCharData,
    output logic            rxParityErr,
    output logic      [7:0] lastTx,
    output logic      [7:0] txCount
);
    int waitCnt;
    int busyCnt;
    initial begin
        rxCharStrobe = 1'b0;
        rxCharData = 8'h00;
        rxParityErr = 1'b0;
    end
    // the shifter is slow on purpose: it takes only when idle, so a new char must wait
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txTake <= 1'b0;
            waitCnt <= 0;
            busyCnt <= 0;
            lastTx <= 8'h00;
            txCount <= 8'h00;
        end else begin
            txTake <= 1'b0;
            if (busyCnt > 0) busyCnt <= busyCnt - 1;
            if (txHoldValid && busyCnt == 0 && !txTake) begin
                if (waitCnt == 7) begin
                    txTake <= 1'b1;
                    lastTx <= txHoldChar;
                    txCount <= txCount + 8'h01;
                    busyCnt <= 10;
                    waitCnt <= 0;
                end else waitCnt <= waitCnt + 1;
            end
        end
    end
    assign txShiftBusy = (busyCnt != 0);
    // data lines show the inverse once the strobe is gone so stale values never match
    task automatic sendChar(input logic [7:0] ch, input logic par);
        @(posedge clk);
        rxCharStrobe <= 1'b1;
        rxCharData <= ch;
        rxParityErr <= par;
        @(posedge clk);
        rxCharStrobe <= 1'b0;
        rxCharData <= ~ch;
        rxParityErr <= ~par;
    endtask : sendChar
endmodule : usc_line_partner
`default_nettype wire

// >>> tb/usc_status_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "usc_cfg.svh"
module usc_status_regs_tb;
    localparam logic [31:0] aMk = `USC_ADDR_MASK;
    localparam logic [31:0] aSt = `USC_ADDR_STATUS;
    localparam logic [31:0] aRx = `USC_ADDR_RX_HOLD;
    localparam logic [31:0] aTx = `USC_ADDR_TX_HOLD;
    localparam logic [31:0] aBd = `USC_ADDR_BAUD;
    localparam logic [31:0] aMt = `USC_ADDR_MATCH;
    localparam logic [31:0] aLk = `USC_ADDR_LOCK;
    localparam logic [31:0] aCt = `USC_ADDR_CTRL;
    localparam logic [31:0] full = 32'hffff_ffff;
    logic        clk, rst_n, busWrite, busRead, rxFrameErr, rxEnabled, txEnabled, pwe;
    logic [31:0] busAddr, busWdata, busRdata;
    logic [3:0]  mir;
    logic        rxGateOpen, txHoldValid, sampleTick, bitTick, wakeReq, irq;
    logic        rxStb, rxPar, txBusy, txTake;
    logic [7:0]  txHoldChar, rxDat, lastTx, txCount;
    int          mismatches, comparisons;
    usc_status_regs u_dut (.clk(clk), .rst_n(rst_n), .busAddr(busAddr),
        .busWdata(busWdata), .busWrite(busWrite), .busRead(busRead), .busRdata(busRdata),
        .rxCharStrobe(rxStb), .rxCharData(rxDat), .rxParityErr(rxPar),
        .rxFrameErr(rxFrameErr), .rxEnabled(rxEnabled), .txEnabled(txEnabled),
        .txShiftBusy(txBusy), .txTake(txTake), .rxDmaDone(mir[0]), .txDmaDone(mir[1]),
        .txDmaBufEmpty(mir[2]), .rxDmaBufFull(mir[3]), .partialWakeEnable(pwe),
        .rxGateOpen(rxGateOpen), .txHoldValid(txHoldValid), .txHoldChar(txHoldChar),
        .sampleTick(sampleTick), .bitTick(bitTick), .wakeReq(wakeReq), .irq(irq));
    usc_line_partner u_far (.clk(clk), .rst_n(rst_n), .txHoldValid(txHoldValid),
        .txHoldChar(txHoldChar), .txShiftBusy(txBusy), .txTake(txTake),
        .rxCharStrobe(rxStb), .rxCharData(rxDat), .rxParityErr(rxPar),
        .lastTx(lastTx), .txCount(txCount));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        busWrite <= 1'b1;
        busAddr <= a;
        busWdata <= d;
        @(posedge clk);
        busWrite <= 1'b0;
    endtask : wr
    task automatic chkReg(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge clk);
        busRead <= 1'b1;
        busAddr <= a;
        @(posedge clk);
        busRead <= 1'b0;
        #1;
        comparisons++;
        if ((busRdata & m) !== e) begin
            mismatches++;
            $display("mismatch t=%0t addr %h got %h want %h", $time, a, busRdata & m, e);
        end
    endtask : chkReg
    task automatic chkBit(input logic g, input logic e);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch t=%0t pin got %b want %b", $time, g, e);
        end
    endtask : chkBit
    task automatic chkCnt(input int g, input int e);
        comparisons++;
        if (g != e) begin
            mismatches++;
            $display("mismatch t=%0t count got %0d want %0d", $time, g, e);
        end
    endtask : chkCnt
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : close_out
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        close_out();
    end
    logic [7:0]  mc [4] = '{8'h2f, 8'h30, 8'h39, 8'h3a};
    logic        me [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    logic [31:0] mb [4] = '{32'h8, 32'h10, 32'h800, 32'h1000};
    logic [15:0] dv [3] = '{16'h0001, 16'h0003, 16'h0000};
    int i, ns, nb;
    initial begin
        rst_n = 1'b0; busWrite = 1'b0; busRead = 1'b0; busAddr = 32'h0; busWdata = 32'h0;
        rxFrameErr = 1'b0; rxEnabled = 1'b1; txEnabled = 1'b1; pwe = 1'b1; mir = 4'h0;
        mismatches = 0;
        comparisons = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        chkReg(aMk, full, 32'h0);
        chkReg(aSt, full, 32'h202);
        chkReg(aBd, full, 32'h0);
        chkReg(aTx, full, 32'h0);
        chkReg(32'h400e0628, full, 32'h0);
        wr(aMk, full);
        chkReg(aMk, full, 32'h0);
        $display("test reset done");
        wr(`USC_ADDR_INT_EN, full);
        chkReg(aMk, full, 32'h9afb);
        wr(`USC_ADDR_INT_DIS, 32'hffff_fff7);
        chkReg(aMk, full, 32'h8);
        for (i = 0; i < 4; i++) begin
            @(posedge clk) mir <= 4'h1 << i;
            chkReg(aSt, full, 32'h202 | mb[i]);
            chkBit(irq, i == 0);
        end
        @(posedge clk) mir <= 4'h0;
        #1 chkBit(irq, 1'b0);
        $display("test mask done");
        u_far.sendChar(8'h41, 1'b0);
        chkReg(aSt, full, 32'h203);
        chkReg(aRx, full, 32'h41);
        chkReg(aSt, full, 32'h202);
        u_far.sendChar(8'h11, 1'b0);
        u_far.sendChar(8'h22, 1'b0);
        chkReg(aSt, full, 32'h223);
        u_far.sendChar(8'h33, 1'b1);
        chkReg(aRx, full, 32'h33);
        chkReg(aSt, full, 32'h2a2);
        @(posedge clk) rxFrameErr <= 1'b1;
        @(posedge clk) rxFrameErr <= 1'b0;
        wr(aCt, 32'h0);
        chkReg(aSt, full, 32'h2e2);
        wr(aCt, 32'h100);
        chkReg(aSt, full, 32'h202);
        u_far.sendChar(8'h44, 1'b0);
        @(posedge clk) rxEnabled <= 1'b0;
        chkReg(aSt, full, 32'h202);
        @(posedge clk) rxEnabled <= 1'b1;
        $display("test receive done");
        wr(aMt, 32'h0039_4030);
        chkReg(aMt, full, 32'h0039_4030);
        for (i = 0; i < 4; i++) begin
            u_far.sendChar(mc[i], 1'b0);
            chkReg(aSt, 32'h8000, {16'h0, me[i], 15'h0});
            chkBit(wakeReq, me[i]);
            wr(aCt, 32'h1100);
        end
        u_far.sendChar(8'h35, 1'b1);
        chkReg(aSt, 32'h8000, 32'h0);
        chkBit(wakeReq, 1'b0);
        wr(aMt, 32'h0039_0030);
        u_far.sendChar(8'h35, 1'b1);
        chkReg(aSt, 32'h8000, 32'h8000);
        wr(aCt, 32'h1100);
        @(posedge clk) pwe <= 1'b0;
        u_far.sendChar(8'h35, 1'b0);
        chkReg(aSt, 32'h8000, 32'h8000);
        chkBit(wakeReq, 1'b0);
        wr(aCt, 32'h1100);
        chkReg(aSt, 32'h8000, 32'h0);
        $display("test compare done");
        chkReg(aRx, full, 32'h35);
        wr(aMt, 32'h0039_1030);
        wr(aCt, 32'h1000);
        #1 chkBit(rxGateOpen, 1'b0);
        u_far.sendChar(8'h41, 1'b0);
        chkReg(aSt, 32'h1, 32'h0);
        u_far.sendChar(8'h31, 1'b0);
        chkReg(aSt, 32'h1, 32'h1);
        chkBit(rxGateOpen, 1'b1);
        chkReg(aRx, full, 32'h31);
        u_far.sendChar(8'h41, 1'b0);
        chkReg(aRx, full, 32'h41);
        wr(aMt, 32'h0);
        wr(aCt, 32'h100);
        $display("test gate done");
        wr(aTx, 32'h5a);
        #1 chkBit(txHoldValid, 1'b1);
        chkBit(txHoldChar === 8'h5a, 1'b1);
        chkReg(aSt, 32'h202, 32'h0);
        for (i = 0; i < 50 && txHoldValid !== 1'b0; i++) @(posedge clk);
        wr(aTx, 32'h6b);
        chkReg(aSt, 32'h202, 32'h0);
        for (i = 0; i < 80 && (txCount !== 8'h02 || txBusy !== 1'b0); i++) @(posedge clk);
        chkReg(aSt, 32'h202, 32'h202);
        chkBit(lastTx === 8'h6b, 1'b1);
        @(posedge clk) txEnabled <= 1'b0;
        chkReg(aSt, 32'h202, 32'h0);
        @(posedge clk) txEnabled <= 1'b1;
        $display("test transmit done");
        foreach (dv[k]) begin
            wr(aBd, {16'h0, dv[k]});
            chkReg(aBd, full, {16'h0, dv[k]});
            ns = 0;
            nb = 0;
            repeat (96) begin
                @(posedge clk);
                #1;
                ns += (sampleTick === 1'b1);
                nb += (bitTick === 1'b1);
            end
            chkCnt(ns, (dv[k] == 0) ? 0 : 96 / dv[k]);
            chkCnt(nb, (dv[k] == 0) ? 0 : 6 / dv[k]);
        end
        $display("test baud done");
        wr(aLk, 32'h1234_5601);
        chkReg(aLk, full, 32'h0);
        wr(aLk, 32'h5541_5201);
        chkReg(aLk, full, 32'h1);
        wr(aBd, 32'h5);
        chkReg(aBd, full, 32'h0);
        wr(aLk, 32'h0000_0000);
        chkReg(aLk, full, 32'h1);
        wr(aLk, 32'h5541_5200);
        wr(aBd, 32'h5);
        chkReg(aBd, full, 32'h5);
        $display("test lock done");
        close_out();
    end
endmodule : usc_status_regs_tb
`default_nettype wire
